// [common/xie_consts.vh]
// Constants for the extended indexed-instruction execution block
`ifndef XIE_CONSTS_VH
`define XIE_CONSTS_VH
// ----------------------------------------------------------------
// APB register byte offsets
// ----------------------------------------------------------------
`define XIE_OFS_CTRL 8'h00
`define XIE_OFS_FPTR0 8'h04
`define XIE_OFS_FPTR1 8'h08
`define XIE_OFS_FPTR2 8'h0c
`define XIE_OFS_BANK 8'h10
`define XIE_OFS_TOS 8'h14
`define XIE_OFS_PC 8'h18
`define XIE_OFS_STAT 8'h1c
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define XIE_CTRL_EXT_BIT 0
`define XIE_CTRL_RST 1'b0
`define XIE_STAT_SRCIND_BIT 4
`define XIE_STAT_DSTBLK_BIT 5
`define XIE_STAT_BADW2_BIT 6
`define XIE_FPTR_RST 12'h000
`define XIE_BANK_RST 4'h0
`define XIE_TOS_RST 21'h000000
`define XIE_PC_RST 21'h000000
// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define XIE_OP_MOVE 8'heb
`define XIE_OP_PUSH 8'hfa
`define XIE_OP_SUBP 8'he9
`define XIE_OP_W2 4'hf
`define XIE_SEL_RET 2'b11
`define XIE_FRAME_IDX 2'd2
`define XIE_OFS_LIMIT 8'h5f
`define XIE_ACCESS_SPLIT 8'h60
`define XIE_ACCESS_HI_BANK 4'hf
`define XIE_IND_ZERO 8'h00
`endif

// [core/xie_ext_exec.v]
// Decode and execution of extended indexed instructions with APB control
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// The register offsets and the APB register port were chosen for this implementation.
`default_nettype none
`include "xie_consts.vh"
module xie_ext_exec #(
   parameter AW = 12,
   parameter [11:0] IND_MASK = 12'hff8, // Arbitrary plain default
   parameter [11:0] IND_MATCH = 12'hfe8, // Arbitrary plain default
   parameter [11:0] PCLOW_ADDR = 12'hff9, // Arbitrary plain default
   parameter [11:0] TOP_U_ADDR = 12'hfff, // Arbitrary plain default
   parameter [11:0] TOP_H_ADDR = 12'hffe, // Arbitrary plain default
   parameter [11:0] TOP_L_ADDR = 12'hffd // Arbitrary plain default
) (
   input wire pclk, // Core clock
   input wire presetn, // Asynchronous reset, active low
   input wire [7:0] paddr, // APB address
   input wire psel, // APB select
   input wire penable, // APB access phase
   input wire pwrite, // APB direction
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output wire pready, // APB ready, always high
   output wire pslverr, // APB error on unmapped address
   input wire instr_valid, // Instruction word offered
   input wire [15:0] instr_word, // Instruction word
   output wire instr_ready, // Block can take a word
   output reg instr_done, // Pulse when an instruction ends
   input wire std_req, // Standard operand to resolve
   input wire [7:0] std_file_addr, // Operand file address
   input wire std_access, // Access bit from opcode
   input wire std_dest_sel, // Destination bit from opcode
   output reg std_valid, // Pulse, resolved address ready
   output reg [AW-1:0] std_eff_addr, // Resolved data address
   output reg std_to_file, // Result goes to file register
   output reg [AW-1:0] mem_addr, // Data memory address
   output reg [7:0] mem_wdata, // Data memory write data
   output reg mem_we, // Data memory write strobe
   output reg mem_re, // Data memory read strobe
   input wire [7:0] mem_rdata, // Read data, cycle after mem_re
   output reg pc_load, // Pulse, load program counter
   output reg [20:0] pc_value // Program counter target
);
   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_MV2 = 3'd1;
   localparam [2:0] ST_MVRD = 3'd2;
   localparam [2:0] ST_MVWR = 3'd3;
   localparam [2:0] ST_RET = 3'd4;

   reg [2:0] state;
   reg ext_en;
   reg [AW-1:0] fptr [0:2];
   reg [3:0] bank_select_reg;
   reg [20:0] return_stack_top;
   reg [6:0] src_off;
   reg src_ind;
   reg flag_srcind;
   reg flag_dstblk;
   reg flag_badw2;
   integer i;
   // ----------------------------------------------------------------
   // Decode of the offered word
   // ----------------------------------------------------------------
   wire take = instr_valid & instr_ready;
   wire [7:0] opc = instr_word[15:8];
   wire is_move = ext_en & (opc == `XIE_OP_MOVE) & instr_word[7];
   wire is_push = ext_en & (opc == `XIE_OP_PUSH);
   wire is_subp = ext_en & (opc == `XIE_OP_SUBP);
   wire [1:0] sub_sel = instr_word[7:6];
   wire is_ret = is_subp & (sub_sel == `XIE_SEL_RET);
   wire w2_ok = instr_word[15:12] == `XIE_OP_W2;
   wire [AW-1:0] frame_pointer = fptr[`XIE_FRAME_IDX];
   // ----------------------------------------------------------------
   // Pointer arithmetic
   // ----------------------------------------------------------------
   // One adder forms move addresses: source in ST_MV2, destination later
   reg [6:0] dst_off;
   wire [6:0] idx_off = (state == ST_MV2) ? src_off : instr_word[6:0];
   wire [6:0] mv_off = (state == ST_MVWR) ? dst_off : idx_off;
   wire [AW-1:0] mv_addr;
   xie_ptr_add #(.AW(AW)) u_mv_add (
      .base(frame_pointer),
      .offs({{(AW-7){1'b0}}, mv_off}),
      .sub(1'b0),
      .sum(mv_addr)
   );
   // Selector 11 always means the frame pointer
   wire [1:0] ptr_idx = is_ret ? `XIE_FRAME_IDX : sub_sel;
   wire [AW-1:0] sub_base = is_push ? frame_pointer : fptr[ptr_idx];
   wire [AW-1:0] sub_offs = is_push ? {{(AW-1){1'b0}}, 1'b1} :
      {{(AW-6){1'b0}}, instr_word[5:0]};
   wire [AW-1:0] sub_res;
   xie_ptr_add #(.AW(AW)) u_sub (
      .base(sub_base),
      .offs(sub_offs),
      .sub(1'b1),
      .sum(sub_res)
   );
   wire [AW-1:0] std_sum;
   xie_ptr_add #(.AW(AW)) u_std_add (
      .base(frame_pointer),
      .offs({{(AW-8){1'b0}}, std_file_addr}),
      .sub(1'b0),
      .sum(std_sum)
   );
   // ----------------------------------------------------------------
   // Address classification
   // ----------------------------------------------------------------
   wire src_is_ind = (mv_addr & IND_MASK) == IND_MATCH;
   wire dst_is_ind = (mv_addr & IND_MASK) == IND_MATCH;
   wire dst_is_prot = (mv_addr == PCLOW_ADDR) | (mv_addr == TOP_U_ADDR) |
      (mv_addr == TOP_H_ADDR) | (mv_addr == TOP_L_ADDR);
   assign instr_ready = (state == ST_IDLE) | (state == ST_MV2);
   // ----------------------------------------------------------------
   // Instruction sequencer
   // ----------------------------------------------------------------
   // Memory strobes are registered; read data arrive one cycle later,
   // which is why the move spends a cycle in ST_MVRD
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         src_off <= 7'h00;
         dst_off <= 7'h00;
         src_ind <= 1'b0;
         mem_addr <= {AW{1'b0}};
         mem_wdata <= 8'h00;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         instr_done <= 1'b0;
         pc_load <= 1'b0;
         pc_value <= `XIE_PC_RST;
      end
      else
      begin
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         instr_done <= 1'b0;
         pc_load <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (take)
               begin
                  if (is_move)
                  begin
                     src_off <= instr_word[6:0];
                     state <= ST_MV2;
                  end
                  else if (is_push)
                  begin
                     mem_addr <= frame_pointer;
                     mem_wdata <= instr_word[7:0];
                     mem_we <= 1'b1;
                     instr_done <= 1'b1;
                  end
                  else if (is_ret)
                  begin
                     pc_value <= return_stack_top;
                     pc_load <= 1'b1;
                     state <= ST_RET;
                  end
                  else
                  begin
                     // Plain subtract, or a word this block does not own
                     instr_done <= 1'b1;
                  end
               end
            end
            ST_MV2:
            begin
               if (take)
               begin
                  if (w2_ok)
                  begin
                     dst_off <= instr_word[6:0];
                     mem_addr <= mv_addr;
                     mem_re <= 1'b1;
                     src_ind <= src_is_ind;
                     state <= ST_MVRD;
                  end
                  else
                  begin
                     // A broken pair is dropped rather than guessed at
                     instr_done <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            ST_MVRD:
            begin
               state <= ST_MVWR;
            end
            ST_MVWR:
            begin
               mem_addr <= mv_addr;
               mem_wdata <= src_ind ? `XIE_IND_ZERO : mem_rdata;
               mem_we <= ~(dst_is_ind | dst_is_prot);
               instr_done <= 1'b1;
               state <= ST_IDLE;
            end
            ST_RET:
            begin
               // Idle cycle while the return target is fetched
               instr_done <= 1'b1;
               state <= ST_IDLE;
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Standard operand resolution
   // ----------------------------------------------------------------
   // Low access-bank operands become frame offsets only when enabled;
   // with the frame pointer at 00h the result equals the literal address
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         std_valid <= 1'b0;
         std_eff_addr <= {AW{1'b0}};
         std_to_file <= 1'b0;
      end
      else
      begin
         std_valid <= std_req;
         if (std_req)
         begin
            std_to_file <= std_dest_sel;
            if (std_access)
               std_eff_addr <= {bank_select_reg, std_file_addr};
            else if (ext_en && std_file_addr <= `XIE_OFS_LIMIT)
               std_eff_addr <= std_sum;
            else if (std_file_addr < `XIE_ACCESS_SPLIT)
               std_eff_addr <= {4'h0, std_file_addr};
            else
               std_eff_addr <= {`XIE_ACCESS_HI_BANK, std_file_addr};
         end
      end
   end

   // ----------------------------------------------------------------
   // APB slave and software-visible registers
   // ----------------------------------------------------------------
   wire apb_wr = psel & penable & pwrite;
   wire apb_setup_rd = psel & ~penable & ~pwrite;
   reg mapped;
   reg [31:0] rd_mux;

   // Zero wait states: read data are latched in the setup phase
   always @*
   begin
      mapped = 1'b1;
      rd_mux = 32'h00000000;
      case (paddr)
         `XIE_OFS_CTRL: rd_mux = {31'h0, ext_en};
         `XIE_OFS_FPTR0: rd_mux = {20'h0, fptr[0]};
         `XIE_OFS_FPTR1: rd_mux = {20'h0, fptr[1]};
         `XIE_OFS_FPTR2: rd_mux = {20'h0, fptr[2]};
         `XIE_OFS_BANK: rd_mux = {28'h0, bank_select_reg};
         `XIE_OFS_TOS: rd_mux = {11'h0, return_stack_top};
         `XIE_OFS_PC: rd_mux = {11'h0, pc_value};
         `XIE_OFS_STAT: rd_mux = {25'h0, flag_badw2, flag_dstblk, flag_srcind, 1'b0, state};
         default: mapped = 1'b0;
      endcase
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (apb_setup_rd)
         prdata <= rd_mux;
   end

   // Instruction updates land first; a same-cycle APB write overrides them
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_en <= `XIE_CTRL_RST;
         for (i = 0; i < 3; i = i + 1)
            fptr[i] <= `XIE_FPTR_RST;
         bank_select_reg <= `XIE_BANK_RST;
         return_stack_top <= `XIE_TOS_RST;
      end
      else
      begin
         if (take && state == ST_IDLE && is_push)
            fptr[`XIE_FRAME_IDX] <= sub_res;
         else if (take && state == ST_IDLE && is_subp)
            fptr[ptr_idx] <= sub_res;
         if (apb_wr)
         begin
            case (paddr)
               `XIE_OFS_CTRL: ext_en <= pwdata[`XIE_CTRL_EXT_BIT];
               `XIE_OFS_FPTR0: fptr[0] <= pwdata[AW-1:0];
               `XIE_OFS_FPTR1: fptr[1] <= pwdata[AW-1:0];
               `XIE_OFS_FPTR2: fptr[2] <= pwdata[AW-1:0];
               `XIE_OFS_BANK: bank_select_reg <= pwdata[3:0];
               `XIE_OFS_TOS: return_stack_top <= pwdata[20:0];
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Sticky status flags, write one to clear, a new event wins
   // ----------------------------------------------------------------
   wire clr_stat = apb_wr & (paddr == `XIE_OFS_STAT);
   wire ev_srcind = (state == ST_MVWR) & src_ind;
   wire ev_dstblk = (state == ST_MVWR) & (dst_is_ind | dst_is_prot);
   wire ev_badw2 = (state == ST_MV2) & take & ~w2_ok;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_srcind <= 1'b0;
         flag_dstblk <= 1'b0;
         flag_badw2 <= 1'b0;
      end
      else
      begin
         flag_srcind <= ev_srcind | (flag_srcind &
            ~(clr_stat & pwdata[`XIE_STAT_SRCIND_BIT]));
         flag_dstblk <= ev_dstblk | (flag_dstblk &
            ~(clr_stat & pwdata[`XIE_STAT_DSTBLK_BIT]));
         flag_badw2 <= ev_badw2 | (flag_badw2 &
            ~(clr_stat & pwdata[`XIE_STAT_BADW2_BIT]));
      end
   end
endmodule
`default_nettype wire

// [core/xie_ptr_add.v]
// Twelve-bit pointer adder/subtractor that wraps inside the data space
`default_nettype none
module xie_ptr_add #(
   parameter AW = 12
) (
   input wire [AW-1:0] base, // Pointer value
   input wire [AW-1:0] offs, // Zero-extended offset
   input wire sub, // High to subtract
   output wire [AW-1:0] sum // Result modulo 2**AW
);
   // ----------------------------------------------------------------
   // Arithmetic
   // ----------------------------------------------------------------
   // Carry out is dropped on purpose so the address never leaves memory
   assign sum = sub ? (base - offs) : (base + offs);
endmodule
`default_nettype wire

// [sim/extended_isa_indexed_exec_bench.sv]
// Self-checking bench for the extended indexed-instruction block
`default_nettype none
`include "xie_consts.vh"
module extended_isa_indexed_exec_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, instr_valid, std_req, std_access, std_dest_sel;
   logic [7:0] paddr, std_file_addr, mem_rdata, src_byte, we_dat;
   logic [31:0] pwdata, rd;
   logic [15:0] instr_word;
   logic [11:0] we_addr, re_addr;
   logic [20:0] pc_got;
   logic err;
   wire [31:0] prdata;
   wire pready, pslverr, instr_ready, instr_done, std_valid, std_to_file, mem_we, mem_re, pc_load;
   wire [11:0] std_eff_addr, mem_addr;
   wire [7:0] mem_wdata;
   wire [20:0] pc_value;
   int n_mismatch = 0, compares = 0, n_we = 0, n_pc = 0, base;
   logic [6:0] pz [4] = '{7'h79, 7'h7d, 7'h7e, 7'h7f};

   xie_ext_exec dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
      .instr_ready(instr_ready), .instr_done(instr_done), .std_req(std_req),
      .std_file_addr(std_file_addr), .std_access(std_access), .std_dest_sel(std_dest_sel),
      .std_valid(std_valid), .std_eff_addr(std_eff_addr), .std_to_file(std_to_file),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
      .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_value(pc_value));

   // Clock at 25 MHz
   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Memory answers the cycle after a read; otherwise shows garbage
   always @(posedge pclk)
      mem_rdata <= mem_re ? src_byte : ~src_byte;

   // Record strobes where they are settled
   always @(negedge pclk)
   begin
      if (mem_we === 1'b1)
      begin
         n_we++;
         we_addr = mem_addr;
         we_dat = mem_wdata;
      end
      if (mem_re === 1'b1)
         re_addr = mem_addr;
      if (pc_load === 1'b1)
      begin
         n_pc++;
         pc_got = pc_value;
      end
   end

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // APB transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following setup never re-drives psel in this step
      @(posedge pclk);
   endtask

   // Offer one word; keep valid up when a second word follows
   task automatic issue(input logic [15:0] w, input logic last);
      logic r;
      instr_valid <= 1'b1;
      instr_word <= w;
      do
      begin
         @(negedge pclk);
         r = instr_ready;
         @(posedge pclk);
      end
      while (r !== 1'b1);
      if (last)
         instr_valid <= 1'b0;
   endtask

   task automatic run(input logic [15:0] w1, w2, input logic two);
      logic d;
      int n = 0;
      issue(w1, !two);
      if (two)
         issue(w2, 1'b1);
      do
      begin
         @(negedge pclk);
         d = instr_done;
         n++;
      end
      while (d !== 1'b1 && n < 20);
      chk(d, 1'b1);
      @(posedge pclk);
   endtask

   // Resolve one standard operand and compare
   task automatic opnd(input logic [7:0] f, input logic a, dsel, input logic [11:0] exp);
      std_req <= 1'b1;
      std_file_addr <= f;
      std_access <= a;
      std_dest_sel <= dsel;
      @(posedge pclk);
      std_req <= 1'b0;
      @(negedge pclk);
      chk({std_valid, std_to_file, std_eff_addr}, {1'b1, dsel, exp});
      @(posedge pclk);
   endtask

   // Indexed move with expected read and write
   task automatic mv(input logic [11:0] fp, input logic [6:0] zs, zd, input logic [7:0] sb,
      input logic we, input logic [7:0] wd);
      int w0;
      apb(1'b1, `XIE_OFS_FPTR2, {20'h0, fp});
      src_byte = sb;
      w0 = n_we;
      run({8'heb, 1'b1, zs}, {9'h1e0, zd}, 1'b1);
      chk(re_addr, 12'(fp + zs));
      chk(n_we - w0, we);
      if (we)
      begin
         chk(we_addr, 12'(fp + zd));
         chk(we_dat, wd);
      end
   endtask

   task automatic finish_test;
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Watchdog: the whole sequence needs well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      finish_test;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {psel, penable, pwrite, instr_valid, std_req, std_access, std_dest_sel} = 7'h00;
      {paddr, std_file_addr, src_byte} = 24'h000000;
      pwdata = 32'h0;
      instr_word = 16'h0;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `XIE_OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      run(16'hfa55, 16'h0, 1'b0);
      chk(n_we, 0);
      opnd(8'h10, 1'b1, 1'b1, 12'h010);
      apb(1'b1, `XIE_OFS_BANK, 32'h5);
      opnd(8'h33, 1'b1, 1'b0, 12'h533);
      opnd(8'h80, 1'b0, 1'b1, 12'hf80);
      apb(1'b1, `XIE_OFS_CTRL, 32'h1);
      apb(1'b1, `XIE_OFS_FPTR2, 32'ha00);
      opnd(8'h2c, 1'b0, 1'b0, 12'ha2c);
      opnd(8'h5f, 1'b0, 1'b1, 12'ha5f);
      opnd(8'h60, 1'b0, 1'b1, 12'hf60);
      opnd(8'h33, 1'b1, 1'b1, 12'h533);
      apb(1'b1, `XIE_OFS_FPTR2, 32'h0);
      opnd(8'h10, 1'b0, 1'b1, 12'h010);
      apb(1'b1, `XIE_OFS_FPTR2, 32'hffa);
      opnd(8'h10, 1'b0, 1'b0, 12'h00a);
      // Push stores at the pointer, then steps it down
      apb(1'b1, `XIE_OFS_FPTR2, 32'h1ec);
      run(16'hfa08, 16'h0, 1'b0);
      chk({we_addr, we_dat}, {12'h1ec, 8'h08});
      apb(1'b0, `XIE_OFS_FPTR2, 32'h0);
      chk(rd, 32'h1eb);
      apb(1'b1, `XIE_OFS_FPTR2, 32'h0);
      run(16'hfa7e, 16'h0, 1'b0);
      apb(1'b0, `XIE_OFS_FPTR2, 32'h0);
      chk(rd, 32'hfff);
      // Subtract on each of the three pointers
      for (int f = 0; f < 3; f++)
      begin
         apb(1'b1, 8'(`XIE_OFS_FPTR0 + 4 * f), 32'h3ff);
         run({8'he9, 2'(f), 6'h23}, 16'h0, 1'b0);
         apb(1'b0, 8'(`XIE_OFS_FPTR0 + 4 * f), 32'h0);
         chk(rd, 32'h3dc);
      end
      apb(1'b1, `XIE_OFS_FPTR0, 32'h010);
      run(16'he93f, 16'h0, 1'b0);
      apb(1'b0, `XIE_OFS_FPTR0, 32'h0);
      chk(rd, 32'hfd1);
      // Selector three subtracts from the frame pointer and returns
      apb(1'b1, 8'h14, 32'h2af);
      apb(1'b1, `XIE_OFS_FPTR2, 32'h3ff);
      run(16'he9e3, 16'h0, 1'b0);
      chk(n_pc, 1);
      chk(pc_got, 21'h2af);
      apb(1'b0, `XIE_OFS_FPTR2, 32'h0);
      chk(rd, 32'h3dc);
      // Indexed moves: plain, wrapping, protected and indirect targets
      mv(12'h080, 7'h05, 7'h06, 8'h33, 1'b1, 8'h33);
      mv(12'hfc0, 7'h7f, 7'h01, 8'h5a, 1'b1, 8'h5a);
      foreach (pz[i])
         mv(12'hf80, 7'h00, pz[i], 8'h11, 1'b0, 8'h00);
      mv(12'hf80, 7'h68, 7'h00, 8'h77, 1'b1, 8'h00);
      mv(12'hf80, 7'h00, 7'h6c, 8'h44, 1'b0, 8'h00);
      // A second word not starting with F drops the pair
      base = n_we;
      run(16'heb81, 16'h0123, 1'b1);
      chk(n_we, base);
      apb(1'b0, `XIE_OFS_STAT, 32'h0);
      chk(rd[6], 1'b1);
      apb(1'b1, `XIE_OFS_STAT, 32'h40);
      apb(1'b0, `XIE_OFS_STAT, 32'h0);
      chk(rd[6], 1'b0);
      finish_test;
   end
endmodule
`default_nettype wire

// [sim/xie_ext_exec_asserts.sv]
// Port-level concurrent checks for the extended indexed-instruction block
`default_nettype none
module xie_ext_exec_asserts #(
   parameter AW = 12,
   parameter [11:0] IND_MASK = 12'hff8,
   parameter [11:0] IND_MATCH = 12'hfe8,
   parameter [11:0] PCLOW_ADDR = 12'hff9,
   parameter [11:0] TOP_U_ADDR = 12'hfff,
   parameter [11:0] TOP_H_ADDR = 12'hffe,
   parameter [11:0] TOP_L_ADDR = 12'hffd
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Access
   input wire logic pslverr, // Error
   input wire logic instr_valid, // Offer
   input wire logic [15:0] instr_word, // Word
   input wire logic instr_ready, // Ready
   input wire logic instr_done, // Done
   input wire logic std_req, // Request
   input wire logic [7:0] std_file_addr, // Operand
   input wire logic std_access, // Access bit
   input wire logic std_dest_sel, // Dest bit
   input wire logic std_valid, // Resolved
   input wire logic [AW-1:0] std_eff_addr, // Address
   input wire logic std_to_file, // To file
   input wire logic [AW-1:0] mem_addr, // Address
   input wire logic [7:0] mem_wdata, // Data
   input wire logic mem_we, // Write
   input wire logic mem_re, // Read
   input wire logic pc_load // Load
);
   // ----------------------------------------------------------------
   // Clocking and step sequences
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire take = instr_valid && instr_ready;
   // A move's second word may begin FA, so it must not be taken for a push
   logic pend_w2;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pend_w2 <= 1'b0;
      else if (take)
         pend_w2 <= !pend_w2 && instr_word[15:7] == 9'h1d7;
   end
   // Return path: load the target, then close one cycle later
   sequence ret_walk;
      pc_load && !instr_done ##1 instr_done && !pc_load;
   endsequence
   // Move: idle cycle after the read, then the write cycle
   sequence move_tail;
      !mem_we ##1 instr_done;
   endsequence
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   err_in_access_a: assert property (pslverr |-> psel && penable)
      else $error("slave error outside access phase");
   write_at_end_a: assert property (mem_we |-> instr_done)
      else $error("memory write not at instruction end");
   push_one_cycle_a: assert property (take && !pend_w2 && instr_word[15:8] == 8'hfa |=>
      instr_done &&
      (!mem_we || mem_wdata == $past(instr_word[7:0])))
      else $error("push literal wrong");
   ret_two_cycle_a: assert property (take && instr_word[15:6] == 10'h3a7 |=>
      ret_walk or (instr_done && !pc_load))
      else $error("subtract return sequence wrong");
   ret_idle_a: assert property (pc_load |=> !mem_we && !mem_re && instr_done)
      else $error("second return cycle not idle");
   move_steps_a: assert property (mem_re |=> move_tail)
      else $error("move write step late");
   dest_guard_a: assert property (mem_we && $past(mem_re, 2) |-> mem_addr != PCLOW_ADDR &&
      mem_addr != TOP_U_ADDR && mem_addr != TOP_H_ADDR && mem_addr != TOP_L_ADDR)
      else $error("move wrote a protected register");
   dest_indirect_a: assert property (mem_we && $past(mem_re, 2) |->
      (mem_addr & IND_MASK) != IND_MATCH)
      else $error("move wrote an indirect register");
   src_zero_a: assert property (mem_we && $past(mem_re, 2) &&
      (($past(mem_addr, 2) & IND_MASK) == IND_MATCH) |-> mem_wdata == 8'h00)
      else $error("indirect source not read as zero");
   std_pulse_a: assert property (std_req |=> std_valid && std_to_file == $past(std_dest_sel))
      else $error("operand resolve pulse wrong");
   std_bank_a: assert property (std_req && std_access |=>
      std_eff_addr[7:0] == $past(std_file_addr))
      else $error("banked operand low byte wrong");
   std_high_a: assert property (std_req && !std_access && std_file_addr > 8'h5f |=>
      std_eff_addr == {4'hf, $past(std_file_addr)})
      else $error("high access operand remapped");
endmodule
bind xie_ext_exec xie_ext_exec_asserts #(.AW(AW), .IND_MASK(IND_MASK), .IND_MATCH(IND_MATCH),
   .PCLOW_ADDR(PCLOW_ADDR), .TOP_U_ADDR(TOP_U_ADDR), .TOP_H_ADDR(TOP_H_ADDR),
   .TOP_L_ADDR(TOP_L_ADDR)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
   .instr_ready(instr_ready), .instr_done(instr_done), .std_req(std_req),
   .std_file_addr(std_file_addr), .std_access(std_access), .std_dest_sel(std_dest_sel),
   .std_valid(std_valid), .std_eff_addr(std_eff_addr), .std_to_file(std_to_file),
   .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
   .pc_load(pc_load));
`default_nettype wire
